/* hw/fep_core.sv */
// instruction timing, fetch/execute overlap and branch/skip sequencing
`timescale 1ns/1ps
`include "fep_regs.svh"
module fep_core
  import fep_pkg::*;
#(
  parameter int PC_W = 13,
  parameter int INSN_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // oscillator selection
  input wire logic [1:0] clk_src_sel,
  input wire logic external_fast_crystal,
  input wire logic internal_fast_rc_osc,
  input wire logic internal_slow_rc_osc,
  output logic sys_clk_en,
  // phase strobes
  output logic [3:0] instruction_phase_clocks,
  output logic insn_cycle_start,
  // program memory fetch port
  output logic [PC_W-1:0] fetch_addr,
  output logic fetch_strobe,
  input wire logic [INSN_W-1:0] fetch_data,
  // decode feedback
  input wire logic dec_extended,
  input wire logic dec_branch,
  input wire logic [PC_W-1:0] dec_target,
  input wire logic skip_taken,
  // execution
  output logic [INSN_W-1:0] exec_insn,
  output logic exec_valid,
  output logic exec_retire,
  output logic dummy_cycle,
  // ALU datapath
  input wire logic [2:0] alu_op,
  input wire logic [7:0] mem_operand,
  input wire logic [7:0] acc_load_data,
  input wire logic acc_load,
  input wire logic acc_write_en,
  input wire logic [8:0] mem_addr_direct,
  input wire logic [8:0] indirect_ptr,
  input wire logic use_indirect,
  output logic [7:0] acc,
  output logic [7:0] alu_result,
  output logic alu_zero,
  output logic alu_carry,
  output logic [8:0] data_mem_addr
);

  ////////////////////////////////////////////////////////////////////////////
  // clock source selection
  logic src_level;
  logic src_prev;

  always_comb begin
    case (clk_src_sel)
      `FEP_SRC_FAST_XTAL: src_level = external_fast_crystal;
      `FEP_SRC_FAST_RC: src_level = internal_fast_rc_osc;
      `FEP_SRC_SLOW_RC: src_level = internal_slow_rc_osc;
      default: src_level = external_fast_crystal;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_level;
    end
  end

  // rising edge of selected source drives the system tick
  assign sys_clk_en = src_level & ~src_prev;

  ////////////////////////////////////////////////////////////////////////////
  // phase generator
  fep_phase_t phase;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= FEP_PH1;
    end else if (sys_clk_en) begin
      case (phase)
        FEP_PH1: phase <= FEP_PH2;
        FEP_PH2: phase <= FEP_PH3;
        FEP_PH3: phase <= FEP_PH4;
        FEP_PH4: phase <= FEP_PH1;
        default: phase <= FEP_PH1;
      endcase
    end
  end

  function automatic logic [3:0] phase_onehot(input fep_phase_t p);
    phase_onehot = 4'h1 << p;
  endfunction

  // one strobe per phase, only one high at a time
  assign instruction_phase_clocks = sys_clk_en ? phase_onehot(phase) : 4'h0;
  assign insn_cycle_start = sys_clk_en && (phase == FEP_PH1);
  logic cycle_end;
  assign cycle_end = sys_clk_en && (phase == FEP_PH4);

  ////////////////////////////////////////////////////////////////////////////
  // sequencing state
  fep_state_t state;
  logic [PC_W-1:0] pc;
  logic [INSN_W-1:0] prefetch;
  logic prefetch_valid;
  logic [PC_W-1:0] next_pc;
  fep_state_t next_state;
  logic next_valid;

  always_comb begin
    next_state = FEP_ST_EXEC;
    next_valid = 1'b1;
    next_pc = pc + PC_W'(1);
    case (state)
      FEP_ST_EXEC: begin
        if (!exec_valid) begin
          next_state = FEP_ST_EXEC;
        end else if (skip_taken) begin
          next_state = FEP_ST_DUMMY;
          next_valid = 1'b0;
        end else if (dec_branch) begin
          next_state = FEP_ST_BRANCH;
          next_valid = 1'b0;
        end else if (dec_extended) begin
          next_state = FEP_ST_EXT2;
          next_valid = 1'b0;
          next_pc = pc;
        end
      end
      FEP_ST_EXT2: begin
        if (dec_branch) begin
          next_state = FEP_ST_BRANCH;
          next_valid = 1'b0;
        end
      end
      FEP_ST_BRANCH: begin
        // extra machine cycle after the branch decode: fetch from the target
        next_pc = dec_target + PC_W'(1);
      end
      FEP_ST_DUMMY: begin
        next_state = FEP_ST_EXEC;
      end
      default: begin
        next_state = FEP_ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= FEP_ST_EXEC;
      exec_valid <= 1'b0;
    end else if (cycle_end) begin
      state <= next_state;
      exec_valid <= next_valid && prefetch_valid;
    end
  end

  // program counter moves at the end of the fourth phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc <= `FEP_PC_RESET;
    end else if (cycle_end) begin
      pc <= next_pc;
    end
  end

  // fetch address: the branch target is fetched in the branch cycle
  assign fetch_addr = (state == FEP_ST_BRANCH) ? dec_target : pc;
  assign fetch_strobe = insn_cycle_start && (state != FEP_ST_EXT2);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prefetch <= '0;
      prefetch_valid <= 1'b0;
    end else if (fetch_strobe) begin
      prefetch <= fetch_data;
      prefetch_valid <= 1'b1;
    end else if (cycle_end && (next_state == FEP_ST_DUMMY)) begin
      prefetch_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      exec_insn <= '0;
    end else if (cycle_end && next_valid) begin
      exec_insn <= prefetch;
    end
  end

  assign dummy_cycle = (state == FEP_ST_DUMMY) || (state == FEP_ST_BRANCH);
  assign exec_retire = cycle_end && (
    (state == FEP_ST_EXEC && exec_valid && !dec_extended && !dec_branch && !skip_taken) ||
    (state == FEP_ST_EXT2 && !dec_branch) || state == FEP_ST_BRANCH ||
    (state == FEP_ST_EXEC && exec_valid && skip_taken));

  ////////////////////////////////////////////////////////////////////////////
  // ALU and accumulator
  logic [8:0] alu_wide;

  always_comb begin
    alu_wide = 9'h000;
    case (alu_op)
      3'h0: alu_wide = {1'b0, acc} + {1'b0, mem_operand};
      3'h1: alu_wide = {1'b0, acc} - {1'b0, mem_operand};
      3'h2: alu_wide = {1'b0, acc & mem_operand};
      3'h3: alu_wide = {1'b0, acc | mem_operand};
      3'h4: alu_wide = {1'b0, acc ^ mem_operand};
      3'h5: alu_wide = {mem_operand[7], mem_operand[6:0], mem_operand[7]};
      3'h6: alu_wide = {1'b0, mem_operand} + 9'h001;
      3'h7: alu_wide = {1'b0, mem_operand} - 9'h001;
      default: alu_wide = 9'h000;
    endcase
  end

  assign alu_result = alu_wide[7:0];
  assign alu_carry = alu_wide[8];
  assign alu_zero = (alu_wide[7:0] == 8'h00);

  // accumulator written in the last phase of an executing cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc <= 8'h00;
    end else if (cycle_end && exec_valid && acc_write_en) begin
      acc <= acc_load ? acc_load_data : alu_result;
    end
  end

  // control registers reached directly or through the pointer
  assign data_mem_addr = use_indirect ? indirect_ptr : mem_addr_direct;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  phase_order_a: assert property (@(posedge clk) disable iff (!reset_n)
    sys_clk_en && phase == FEP_PH4 |=> phase == FEP_PH1)
    else $error("phase did not wrap to first");
  strobe_onehot_a: assert property (@(posedge clk) disable iff (!reset_n)
    $onehot0(instruction_phase_clocks))
    else $error("phase strobes overlap");
  pc_step_a: assert property (@(posedge clk) disable iff (!reset_n)
    cycle_end && state == FEP_ST_EXEC && !dec_extended |=> pc == $past(pc) + PC_W'(1))
    else $error("pc did not step");
  fetch_phase_a: assert property (@(posedge clk) disable iff (!reset_n)
    fetch_strobe |-> instruction_phase_clocks[0])
    else $error("fetch outside first phase");
  exec_late_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec_retire |-> instruction_phase_clocks[3])
    else $error("retire outside execute phases");
  skip_dummy_a: assert property (@(posedge clk) disable iff (!reset_n)
    cycle_end && state == FEP_ST_EXEC && exec_valid && skip_taken |=> dummy_cycle && !exec_valid)
    else $error("skip did not insert dummy");
  branch_extra_a: assert property (@(posedge clk) disable iff (!reset_n)
    cycle_end && state == FEP_ST_EXEC && exec_valid && dec_branch && !skip_taken
    |=> state == FEP_ST_BRANCH)
    else $error("branch lacks extra cycle");
  ext_two_a: assert property (@(posedge clk) disable iff (!reset_n)
    cycle_end && state == FEP_ST_EXEC && exec_valid && dec_extended && !dec_branch && !skip_taken
    |=> state == FEP_ST_EXT2)
    else $error("extended not two cycles");
  reset_phase_a: assert property (@(posedge clk)
    $rose(reset_n) |-> phase == FEP_PH1)
    else $error("phase not first after reset");

endmodule

/* pkg/fep_regs.svh */
// timing constants and clock source select codes for the fetch/execute pipeline control
`ifndef FEP_REGS_SVH
`define FEP_REGS_SVH
`define FEP_PHASES 4
`define FEP_PC_RESET 13'h0000
`define FEP_SRC_FAST_XTAL 2'h0
`define FEP_SRC_FAST_RC 2'h1
`define FEP_SRC_SLOW_RC 2'h2
`define FEP_SYS_CLK_NS 50
`define FEP_INSN_NS (`FEP_SYS_CLK_NS * `FEP_PHASES)
`endif

/* pkg/fep_pkg.sv */
// types for the fetch/execute pipeline control
package fep_pkg;
  typedef enum logic [1:0] {
    FEP_PH1,
    FEP_PH2,
    FEP_PH3,
    FEP_PH4
  } fep_phase_t;
  typedef enum logic [1:0] {
    FEP_ST_EXEC,
    FEP_ST_EXT2,
    FEP_ST_BRANCH,
    FEP_ST_DUMMY
  } fep_state_t;
endpackage

/* verif/fep_mem_model.sv */
// program memory model behind the fetch port
`timescale 1ns/1ps
module fep_mem_model (
  // clock
  input wire logic clk,
  // fetch port
  input wire logic [12:0] fetch_addr,
  input wire logic fetch_strobe,
  output logic [15:0] fetch_data
);
  logic [15:0] junk = 16'h0000;
  // bus shows a moving pattern when not strobed
  always @(posedge clk) junk <= junk + 16'h3C3D;
  assign fetch_data = fetch_strobe ? ({3'h0, fetch_addr} ^ 16'hA500) : junk;
endmodule

/* verif/two_stage_fetch_execute_pipeline_tb.sv */
// testbench for the fetch/execute pipeline control
`timescale 1ns/1ps
`include "fep_regs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module two_stage_fetch_execute_pipeline_tb;
  import fep_pkg::*;
  logic clk = 0, reset_n = 0, xtal = 0, frc = 1, slow_rc = 0;
  logic [1:0] clk_src_sel = `FEP_SRC_FAST_XTAL;
  logic dec_extended = 0, dec_branch = 0, skip_taken = 0;
  logic acc_load = 0, acc_write_en = 0, use_indirect = 0;
  logic [12:0] dec_target = 13'h0100, fetch_addr;
  logic [2:0] alu_op = 3'h0;
  logic [7:0] mem_operand = 8'h00, acc_load_data = 8'h00, acc, alu_result;
  logic [8:0] mem_addr_direct = 9'h012, indirect_ptr = 9'h1A5, data_mem_addr;
  logic [15:0] fetch_data, exec_insn;
  logic [3:0] instruction_phase_clocks;
  logic sys_clk_en, insn_cycle_start, fetch_strobe, exec_valid, exec_retire;
  logic dummy_cycle, alu_zero, alu_carry;
  int mismatches = 0, n_tests = 0;
  fep_core i_dut (.clk(clk), .reset_n(reset_n), .clk_src_sel(clk_src_sel),
    .external_fast_crystal(xtal), .internal_fast_rc_osc(frc),
    .internal_slow_rc_osc(slow_rc), .sys_clk_en(sys_clk_en),
    .instruction_phase_clocks(instruction_phase_clocks),
    .insn_cycle_start(insn_cycle_start), .fetch_addr(fetch_addr),
    .fetch_strobe(fetch_strobe), .fetch_data(fetch_data), .dec_extended(dec_extended),
    .dec_branch(dec_branch), .dec_target(dec_target), .skip_taken(skip_taken),
    .exec_insn(exec_insn), .exec_valid(exec_valid), .exec_retire(exec_retire),
    .dummy_cycle(dummy_cycle), .alu_op(alu_op), .mem_operand(mem_operand),
    .acc_load_data(acc_load_data), .acc_load(acc_load), .acc_write_en(acc_write_en),
    .mem_addr_direct(mem_addr_direct), .indirect_ptr(indirect_ptr),
    .use_indirect(use_indirect), .acc(acc), .alu_result(alu_result),
    .alu_zero(alu_zero), .alu_carry(alu_carry), .data_mem_addr(data_mem_addr));
  fep_mem_model i_mem (.clk(clk), .fetch_addr(fetch_addr), .fetch_strobe(fetch_strobe),
    .fetch_data(fetch_data));
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    #1;
    xtal = ~xtal;
    frc = ~frc;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic timed_out();
    mismatches++;
    $display("MISMATCH %0t wait ran out", $time);
    tally_and_finish();
  endtask
  // returns at the low half of the next tick cycle
  task automatic next_tick();
    int i;
    for (i = 0; i < 40; i++) begin
      @(negedge clk);
      if (sys_clk_en === 1'b1) return;
    end
    timed_out();
  endtask
  task automatic to_phase(input int p);
    int i;
    for (i = 0; i < 8; i++) begin
      next_tick();
      if (instruction_phase_clocks === (4'h1 << p)) return;
    end
    timed_out();
  endtask
  // inputs change a small delay after the rising edge
  task automatic after_edge();
    @(posedge clk);
    #1;
  endtask
  // flags raised just after the phase 3 tick edge, dropped just after the phase 4 tick edge
  task automatic decode(input logic br, input logic ex, input logic sk);
    to_phase(2);
    after_edge();
    dec_branch = br;
    dec_extended = ex;
    skip_taken = sk;
    to_phase(3);
    `CHK(exec_retire, !(br || ex))
    after_edge();
    dec_branch = 0;
    dec_extended = 0;
    skip_taken = 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_phases();
    int p;
    next_tick();
    `CHK(fetch_addr, `FEP_PC_RESET)
    for (p = 0; p < 8; p++) begin
      `CHK(instruction_phase_clocks, 4'h1 << (p % 4))
      `CHK(insn_cycle_start, p % 4 == 0)
      `CHK(fetch_strobe, p % 4 == 0)
      next_tick();
    end
  endtask
  task automatic t_seq();
    logic [12:0] a;
    to_phase(0);
    a = fetch_addr;
    to_phase(0);
    `CHK(fetch_addr, a + 13'h1)
    `CHK(exec_insn, {3'h0, a} ^ 16'hA500)
    `CHK(exec_valid, 1'b1)
  endtask
  task automatic t_branch();
    decode(1, 0, 0);
    to_phase(0);
    `CHK(dummy_cycle, 1'b1)
    `CHK(fetch_addr, dec_target)
    to_phase(3);
    `CHK(exec_retire, 1'b1)
    to_phase(0);
    `CHK(fetch_addr, dec_target + 13'h1)
    `CHK(dummy_cycle, 1'b0)
    `CHK(exec_insn, {3'h0, dec_target} ^ 16'hA500)
  endtask
  task automatic t_ext_skip();
    decode(0, 1, 0);
    to_phase(0);
    `CHK(fetch_strobe, 1'b0)
    to_phase(3);
    `CHK(exec_retire, 1'b1)
    to_phase(0);
    `CHK(fetch_strobe, 1'b1)
    decode(0, 0, 1);
    to_phase(0);
    `CHK(exec_valid, 1'b0)
    `CHK(dummy_cycle, 1'b1)
    to_phase(0);
    `CHK(exec_valid, 1'b1)
    `CHK(exec_insn, {3'h0, dec_target + 13'h3} ^ 16'hA500)
  endtask
  task automatic t_src();
    int i;
    int ticks;
    after_edge();
    clk_src_sel = `FEP_SRC_SLOW_RC;
    for (i = 0; i < 6; i++) begin
      @(negedge clk);
      if (i > 1) `CHK(sys_clk_en, 1'b0)
    end
    after_edge();
    slow_rc = 1;
    @(negedge clk);
    `CHK(sys_clk_en, 1'b1)
    @(negedge clk);
    `CHK(sys_clk_en, 1'b0)
    after_edge();
    clk_src_sel = `FEP_SRC_FAST_RC;
    slow_rc = 0;
    @(posedge clk);
    ticks = 0;
    for (i = 0; i < 8; i++) begin
      @(negedge clk);
      if (sys_clk_en === 1'b1) ticks++;
    end
    `CHK(ticks, 4)
  endtask
  task automatic alu_case(input logic [2:0] op, input logic [9:0] exp);
    after_edge();
    alu_op = op;
    @(negedge clk);
    `CHK({alu_carry, alu_zero, alu_result}, exp)
  endtask
  task automatic t_alu();
    after_edge();
    acc_load = 1;
    acc_load_data = 8'h5A;
    acc_write_en = 1;
    to_phase(3);
    after_edge();
    acc_load = 0;
    acc_write_en = 0;
    mem_operand = 8'hA6;
    alu_op = 3'h0;
    @(negedge clk);
    `CHK(acc, 8'h5A)
    `CHK({alu_carry, alu_zero, alu_result}, 10'h300)
    `CHK(data_mem_addr, 9'h012)
    alu_case(3'h1, 10'h2B4);
    alu_case(3'h3, 10'h0FE);
    alu_case(3'h4, 10'h0FC);
    alu_case(3'h5, 10'h24D);
    alu_case(3'h6, 10'h0A7);
    alu_case(3'h7, 10'h0A5);
    after_edge();
    alu_op = 3'h2;
    use_indirect = 1;
    acc_write_en = 1;
    @(negedge clk);
    `CHK(alu_result, 8'h02)
    `CHK(data_mem_addr, 9'h1A5)
    to_phase(3);
    after_edge();
    acc_write_en = 0;
    `CHK(acc, 8'h02)
  endtask
  // reset in mid-run must restart at the first phase
  task automatic t_reset();
    after_edge();
    reset_n = 0;
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1;
    `CHK(exec_valid, 1'b0)
    `CHK(acc, 8'h00)
    next_tick();
    `CHK(instruction_phase_clocks, 4'h1)
    `CHK(fetch_addr, `FEP_PC_RESET)
    `CHK(fetch_strobe, 1'b1)
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1;
    t_phases();
    t_seq();
    t_branch();
    t_ext_skip();
    t_alu();
    t_reset();
    t_src();
    tally_and_finish();
  end
endmodule
